//--- design/dac_group_address_decoder_pkg.sv
// constants for the channel group address decoder
package dac_group_address_decoder_pkg;
    localparam int group_count = 4;
    localparam int regs_per_group = 10;
    localparam int channel_count = 40;
    localparam int addr_width = 8;
    localparam int data_width = 14;
    localparam int group_lsb = 4;
    localparam int index_msb = 3;
    localparam logic [3:0] group_all = 4'h0;
    localparam logic [3:0] last_index = 4'h9;
    localparam logic [13:0] soft_reset_code = 14'h3fff;
    localparam logic [1:0] sel_special = 2'h0;
    localparam logic [1:0] sel_gain = 2'h1;
    localparam logic [1:0] sel_offset = 2'h2;
    localparam logic [1:0] sel_data = 2'h3;
    localparam logic [39:0] no_channels = 40'h00_0000_0000;
    localparam logic [39:0] all_channels = 40'hff_ffff_ffff;
endpackage

//--- design/dac_group_address_decoder.sv
// channel group address decoder: turns each host write into per-channel register strobes, or into a special-function pulse for select 00
// Notes on behaviour
// RULE1: every write carries an 8-bit channel address selecting individual registers.
// RULE2: two register-select bits choose data, offset, gain or special-function target.
// RULE3: address bits 7..4 are a group mask; zero means all 40 channels.
// RULE4: with all channels selected, address bits 3..0 are ignored.
// RULE5: address bits 3..0 index register 0 to 9 inside each selected group.
// RULE6: outputs power up cleared to test ground until the analog section is up.
// RULE7: select 01 targets gain registers; select 00 targets the special-function register.
// RULE8: special-function write of all ones is a soft reset to reference ground.
// RULE9: index values 10 to 15 select nothing unless all channels are selected.
`timescale 1ns/1ps
module dac_group_address_decoder #(
    parameter int channels = dac_group_address_decoder_pkg::channel_count,
    parameter int data_bits = dac_group_address_decoder_pkg::data_width
) (
    input wire logic clk, // system clock, 50 MHz
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic write_strobe, // one-cycle host write request
    input wire logic [7:0] channel_address, // group mask and register index
    input wire logic register_select_high, // register select bit 1
    input wire logic register_select_low, // register select bit 0
    input wire logic [data_bits-1:0] write_data, // value written
    input wire logic analog_ready, // analog section powered up
    output logic [channels-1:0] data_write, // per-channel input register strobe
    output logic [channels-1:0] offset_write, // per-channel offset register strobe
    output logic [channels-1:0] gain_write, // per-channel gain register strobe
    output logic [channels-1:0] step_write, // per-channel step adjust strobe
    output logic [data_bits-1:0] write_value, // data that goes with the strobes
    output logic soft_reset, // one-cycle soft reset pulse
    output logic special_function_write, // one-cycle special-function write pulse
    output logic output_clear // outputs held at test ground while high
);
    localparam int per_group = dac_group_address_decoder_pkg::regs_per_group;

    logic [1:0] select;
    logic [3:0] group_mask;
    logic [3:0] reg_index;
    logic [channels-1:0] target;
    logic step_mode;
    // next_ values are the combinational inputs of the per-concern registers
    logic next_step_mode;
    logic [channels-1:0] next_data_write;
    logic [channels-1:0] next_offset_write;
    logic [channels-1:0] next_gain_write;
    logic [channels-1:0] next_step_write;
    logic next_special;
    logic next_soft_reset;
    logic next_output_clear;

    assign select = {register_select_high, register_select_low}; // RULE2
    assign group_mask = channel_address[7:dac_group_address_decoder_pkg::group_lsb]; // RULE1 RULE3
    assign reg_index = channel_address[dac_group_address_decoder_pkg::index_msb:0]; // RULE1

    // a channel is hit when the whole device is addressed, or when its group is enabled
    // and the index names its register, so indices 10 to 15 reach a channel only when the whole device is addressed
    function automatic logic channel_hit(
        input logic [3:0] mask_now,
        input logic [3:0] index_now,
        input int grp,
        input int reg_no
    );
        logic hit;
        hit = 1'b0;
        if (mask_now == dac_group_address_decoder_pkg::group_all) begin
            hit = 1'b1; // RULE3 RULE4
        end else if (mask_now[grp] && index_now == 4'(reg_no)) begin
            hit = 1'b1; // RULE5 RULE9
        end
        return hit;
    endfunction

    // channel map: group g owns channels g*10 .. g*10+9
    // group A sits on bits 0 to 9 and group D on bits 30 to 39 of every strobe array
    genvar g;
    genvar r;
    generate
        for (g = 0; g < dac_group_address_decoder_pkg::group_count; g++) begin : grp
            for (r = 0; r < per_group; r++) begin : chn
                assign target[g*per_group+r] =
                    channel_hit(group_mask, reg_index, g, r); // RULE3 RULE5 RULE9
            end
        end
    endgenerate

    // a special-function write with a non-reset code and write_data bit 7 set arms step mode: the next data
    // writes then go to the step adjust registers instead of the input registers
    // step mode lasts until the next special-function write; a soft reset disarms it
    // as well, so data writes after a reset always land in the input registers
    always_comb begin
        next_step_mode = step_mode;
        if (write_strobe && select == dac_group_address_decoder_pkg::sel_special) begin
            next_step_mode = (write_data != dac_group_address_decoder_pkg::soft_reset_code)
                && write_data[7];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_mode <= 1'b0;
        end else if (ce) begin
            step_mode <= next_step_mode;
        end
    end

    // one routing function serves all four arrays so their decodes cannot drift apart;
    // the select code is compared whole, so no other code leaks into an array
    function automatic logic [channels-1:0] route(
        input logic [1:0] sel_now,
        input logic [1:0] sel_want,
        input logic [channels-1:0] map
    );
        logic [channels-1:0] result;
        result = '0;
        if (sel_now == sel_want) begin
            result = map;
        end
        return result;
    endfunction

    // strobe values for the coming cycle; each strobe lasts one enabled cycle
    always_comb begin
        next_data_write = '0;
        next_offset_write = '0;
        next_gain_write = '0;
        next_step_write = '0;
        next_special = 1'b0;
        next_soft_reset = 1'b0;
        // group mask and register index are already folded into target
        if (write_strobe) begin
            next_offset_write = route(select,
                dac_group_address_decoder_pkg::sel_offset, target);
            next_gain_write = route(select,
                dac_group_address_decoder_pkg::sel_gain, target); // RULE7
            if (step_mode) begin
                next_step_write = route(select,
                    dac_group_address_decoder_pkg::sel_data, target);
            end else begin
                next_data_write = route(select,
                    dac_group_address_decoder_pkg::sel_data, target);
            end
            if (select == dac_group_address_decoder_pkg::sel_special) begin
                next_special = 1'b1; // RULE7
                next_soft_reset = (write_data
                    == dac_group_address_decoder_pkg::soft_reset_code); // RULE8
            end
        end
    end

    // one register per strobe array; ce low holds every pulse, so a consumer that is
    // stalled by the same enable still sees it once it runs again
    // the cost is that a pulse can last several clocks while ce is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_write <= '0;
        end else if (ce) begin
            data_write <= next_data_write;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            offset_write <= '0;
        end else if (ce) begin
            offset_write <= next_offset_write;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_write <= '0;
        end else if (ce) begin
            gain_write <= next_gain_write;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_write <= '0;
        end else if (ce) begin
            step_write <= next_step_write;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            special_function_write <= 1'b0;
        end else if (ce) begin
            special_function_write <= next_special;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset <= 1'b0;
        end else if (ce) begin
            soft_reset <= next_soft_reset;
        end
    end

    // clear follows the analog supply state one enabled clock later
    assign next_output_clear = !analog_ready; // RULE6

    // write_value keeps the last accepted data so a slow consumer can read it late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_value <= '0;
        end else if (ce && write_strobe) begin
            write_value <= write_data;
        end
    end

    // clear is released only once the analog side reports ready; it is not re-entered
    // on a soft reset, which drives the outputs to reference ground through the data path
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_clear <= 1'b1; // RULE6
        end else if (ce) begin
            output_clear <= next_output_clear; // RULE6
        end
    end
endmodule // dac_group_address_decoder

//--- test/dac_group_address_decoder_properties.sv
// concurrent checks on the channel group decoder ports
`timescale 1ns/1ps
module dac_group_address_decoder_properties (input logic clk, rst_n, ce, write_strobe,
    input logic analog_ready, register_select_high, register_select_low, soft_reset,
    input logic special_function_write, output_clear, input logic [7:0] channel_address,
    input logic [13:0] write_data, write_value, input logic [39:0] gain_write, offset_write);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire w = write_strobe && ce;
    wire [1:0] s = {register_select_high, register_select_low};
    wire [3:0] m = channel_address[7:4];
    wire n = channel_address[3:0] > 4'h9;
    a_gain_all: assert property (w && s == 2'h1 && !m |=> &gain_write) else $error("gain");
    a_group_count: assert property (w && s == 2'h2 && m && !n
        |=> $countones(offset_write) == $countones($past(m))) else $error("groups");
    a_no_index: assert property (w && m && n |=> !offset_write) else $error("index");
    a_soft_rst: assert property (w && !s && &write_data |=> soft_reset) else $error("sr");
    a_sfr_pulse: assert property (w && !s |=> special_function_write) else $error("sfr");
    a_last_data: assert property (w |=> write_value == $past(write_data)) else $error("v");
    a_clear_held: assert property (ce && !analog_ready |=> output_clear) else $error("clear");
    a_clear_free: assert property (ce && analog_ready |=> !output_clear) else $error("free");
    c_soft: cover property (soft_reset);
    c_bcast: cover property (&gain_write);
    c_release: cover property ($fell(output_clear));
endmodule // dac_group_address_decoder_properties
bind dac_group_address_decoder dac_group_address_decoder_properties chk_u (.*);

//--- test/host_model.sv
// host model issuing single-cycle register writes
`timescale 1ns/1ps
module host_model (input logic clk, output logic write_strobe = 1'b0,
    output logic register_select_high = 1'b0, output logic register_select_low = 1'b0,
    output logic [7:0] channel_address = 8'h00, output logic [13:0] write_data = 14'h0000);
    task automatic wr(input logic [7:0] a, input logic [1:0] s, input logic [13:0] d);
        @(negedge clk);
        {write_strobe, register_select_high, register_select_low, channel_address, write_data} =
            {1'b1, s, a, d};
        @(negedge clk);
        // released address and data lines show the inverse so a stale value cannot pass
        {write_strobe, channel_address, write_data} = {1'b0, ~a, ~d};
    endtask
endmodule // host_model

//--- test/test_dac_group_address_decoder.sv
// self-checking bench for the channel group decoder
`timescale 1ns/1ps
module test_dac_group_address_decoder;
    logic clk = 1'b0, rst_n = 1'b0, analog_ready = 1'b0, write_strobe, register_select_high;
    logic register_select_low, soft_reset, special_function_write, output_clear;
    logic [7:0] channel_address;
    logic [13:0] write_data, write_value;
    logic ce = 1'b1;
    logic [39:0] data_write, offset_write, gain_write, step_write, mask = 40'h0;
    int errors = 0, num_checks = 0;
    host_model host_u (.*);
    dac_group_address_decoder dut_u (.*);
    initial forever #10 clk = ~clk;
    task automatic chk(input string n, input logic [39:0] seen, want);
        num_checks++;
        errors += int'(seen !== want);
        if (seen !== want) $display("ERROR %s expected %h seen %h", n, want, seen);
    endtask
    task automatic final_report(input int extra);
        errors += extra;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic power_up();
        rst_n = 1'b1;
        @(negedge clk);
        chk("clear", 40'(output_clear), 40'h1);
        analog_ready = 1'b1;
        @(negedge clk);
        chk("clear", 40'(output_clear), 40'h0);
    endtask
    task automatic decode();
        for (int m = 1; m < 16; m++) begin
            for (int g = 0; g < 4; g++) mask[g * 10 + 9] = m[g];
            host_u.wr({m[3:0], 4'h9}, 2'h2, 14'(m));
            chk("offset", offset_write, mask);
        end
        host_u.wr(8'h0c, 2'h1, 14'h0123);
        chk("gain", gain_write, '1);
        host_u.wr(8'h1a, 2'h2, 14'h0001);
        chk("index", offset_write, 40'h0);
        host_u.wr(8'h00, 2'h0, 14'h3fff);
        chk("reset", 40'({special_function_write, soft_reset}), 40'h3);
        chk("value", 40'(write_value), 40'h3fff);
    endtask
    task automatic data_path();
        host_u.wr(8'h13, 2'h3, 14'h0055);
        chk("data", data_write, 40'h8);
        chk("step", step_write, 40'h0);
        host_u.wr(8'h00, 2'h0, 14'h0080);
        chk("special", 40'({special_function_write, soft_reset}), 40'h2);
        host_u.wr(8'h25, 2'h3, 14'h0001);
        chk("step", step_write, 40'h8000);
        chk("data", data_write, 40'h0);
        host_u.wr(8'h00, 2'h0, 14'h0000);
        host_u.wr(8'h03, 2'h3, 14'h0002);
        chk("data", data_write, '1);
    endtask
    task automatic hold();
        ce = 1'b0;
        analog_ready = 1'b0;
        host_u.wr(8'h13, 2'h3, 14'h0aaa);
        chk("hold", data_write, '1);
        chk("hold", 40'(write_value), 40'h0002);
        chk("hold", 40'(output_clear), 40'h0);
        ce = 1'b1;
        analog_ready = 1'b1;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        power_up();
        decode();
        data_path();
        hold();
        final_report(0);
    end
    initial #20000 final_report(1);
endmodule // test_dac_group_address_decoder
